// File: design/rsw_pkg.sv
// package for the reset sequencer, supply monitor and watchdog block
// assumes one 250 MHz clock and a synchronous active high reset
package rsw_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WDT_RESTART = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_SVM_LEVEL = 8'h0c;
    localparam logic [7:0] OFS_CLK_SEL = 8'h10;

    // control register fields
    localparam int CTRL_SW_RESET = 0;
    localparam int CTRL_SVM_RST_EN = 1;
    localparam int CTRL_SVM_IRQ_FALL = 2;
    localparam int CTRL_SVM_IRQ_RISE = 3;
    localparam int CTRL_WDT_EN = 4;
    localparam int CTRL_WDT_EXC = 5;
    localparam int CTRL_WDT_PRE_LO = 8;
    localparam int CTRL_WDT_PRE_HI = 11;

    // status register fields
    localparam int STAT_WDT_FIRED = 0;
    localparam int STAT_RAM_INVALID = 1;
    localparam int STAT_CAUSE_LO = 2;
    localparam int STAT_CAUSE_HI = 4;
    localparam int STAT_SVM_ABOVE = 5;
    localparam int STAT_XTAL_READY = 6;
    localparam int STAT_STATE_LO = 8;

    // clock select fields
    localparam int CLK_HS_XTAL = 0;
    localparam int CLK_SLOW_LO = 1;
    localparam int CLK_SLOW_HI = 2;
    localparam int CLK_SLOW_LOCK = 3;

    // reset values
    localparam logic RST_SVM_RST_EN = 1'b1;
    localparam logic RST_WDT_EN = 1'b1;
    localparam logic [3:0] RST_WDT_PRE = 4'hb;
    localparam logic [2:0] RST_SVM_LEVEL = 3'h1;
    localparam logic [1:0] RST_SLOW_SEL = 2'h0;

    // threshold codes: 1.95,2.0,2.1,2.2,2.3,2.4,2.7,3.0 V
    localparam logic [2:0] SVM_LEVEL_2V0 = 3'h1;

    // slow clock sources
    localparam logic [1:0] SLOW_RC = 2'h0;
    localparam logic [1:0] SLOW_EXT = 2'h1;
    localparam logic [1:0] SLOW_XTAL = 2'h2;

    // reset cause codes
    localparam logic [2:0] CAUSE_POR = 3'h0;
    localparam logic [2:0] CAUSE_EXT = 3'h1;
    localparam logic [2:0] CAUSE_SW = 3'h2;
    localparam logic [2:0] CAUSE_WDT = 3'h3;
    localparam logic [2:0] CAUSE_SVM = 3'h4;

    // timing
    localparam int CLK_MHZ = 250;
    localparam int T_OSC_NS = 13000;
    localparam int T_REG_NS = 15000;
    localparam int T_NVM_NS = 150000;
    localparam int T_LOAD_NS = 2500;
    localparam int T_EXT_MIN_NS = 1000;
    localparam int T_WDT_BASE_NS = 8000000;
    localparam int OSC_CYC = (T_OSC_NS * CLK_MHZ + 999) / 1000;
    localparam int REG_CYC = (T_REG_NS * CLK_MHZ + 999) / 1000;
    localparam int NVM_CYC = (T_NVM_NS * CLK_MHZ + 999) / 1000;
    localparam int LOAD_CYC = (T_LOAD_NS * CLK_MHZ + 999) / 1000;
    localparam int EXT_MIN_CYC = (T_EXT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int WDT_BASE_CYC = T_WDT_BASE_NS / 1000 * CLK_MHZ;

    typedef enum logic [7:0] {
        SQ_HOLD = 8'h01,
        SQ_OSC = 8'h02,
        SQ_SVM0 = 8'h04,
        SQ_REG = 8'h08,
        SQ_NVM = 8'h10,
        SQ_LOAD = 8'h20,
        SQ_SVM1 = 8'h40,
        SQ_RUN = 8'h80
    } rsw_state_type;
endpackage : rsw_pkg

// File: design/rsw_top.sv
// reset sequencer with supply monitor control and watchdog
// assumes analog comparator, regulators and memory init live outside
module rsw_top #(
    parameter int NVM_WAIT_CYC = rsw_pkg::NVM_CYC,
    parameter int WDT_BASE = rsw_pkg::WDT_BASE_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // supply and pin inputs, asynchronous
    input wire logic POR_OK,
    input wire logic EXT_RESET_N,
    input wire logic SVM_ABOVE,
    input wire logic XTAL_READY,
    // power state, same clock
    input wire logic SLEEP,
    input wire logic DBG_HALT,
    // memory init
    input wire logic [2:0] NVM_SVM_LEVEL,
    output logic NVM_INIT_REQ,
    // analog controls
    output logic HS_RC_EN,
    output logic XTAL_EN,
    output logic REG_EN,
    output logic [2:0] SVM_LEVEL_SEL,
    output logic HS_CLK_XTAL,
    output logic [1:0] SLOW_CLK_SEL,
    // to cpu
    output logic SYS_RST_N,
    output logic SVM_IRQ,
    output logic WDT_EXC,
    // register port
    input wire logic [rsw_pkg::ADDR_W-1:0] ADDR,
    input wire logic [rsw_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [rsw_pkg::DATA_W-1:0] RDATA
);
    import rsw_pkg::*;

    localparam logic [15:0] OSC_C = 16'(OSC_CYC - 1);
    localparam logic [15:0] REG_C = 16'(REG_CYC - 1);
    localparam logic [15:0] NVM_C = 16'(NVM_WAIT_CYC - 1);
    localparam logic [15:0] LOAD_C = 16'(LOAD_CYC - 1);
    localparam logic [15:0] EXT_C = 16'(EXT_MIN_CYC);
    localparam logic [31:0] WDT_B = 32'(WDT_BASE);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // two-stage synchronisers
    logic [3:0] async_in;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    assign async_in = {XTAL_READY, SVM_ABOVE, EXT_RESET_N, POR_OK};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge CLK) begin
                if (RST) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic por_ok;
    logic ext_n;
    logic svm_above;
    logic xtal_ready;
    assign por_ok = sync2_q[0];
    assign ext_n = sync2_q[1];
    assign svm_above = sync2_q[2];
    assign xtal_ready = sync2_q[3];

    rsw_state_type state_q;
    logic [15:0] tmr_q;
    logic ext_hold_q;
    logic [15:0] ext_cnt_q;
    logic chip_rst_q;
    logic [2:0] cause_q;
    logic sleep_q;
    logic svm_prev_q;

    // control registers
    logic svm_rst_en_q;
    logic irq_fall_en_q;
    logic irq_rise_en_q;
    logic wdt_en_q;
    logic wdt_exc_mode_q;
    logic [3:0] wdt_pre_q;
    logic [2:0] svm_level_q;
    logic hs_xtal_q;
    logic [1:0] slow_sel_q;
    logic slow_lock_q;
    logic wdt_fired_q;
    logic ram_invalid_q;
    logic [31:0] wdt_cnt_q;

    logic wr_ctrl;
    logic wr_stat;
    logic sw_rst;
    logic wdt_expire;
    logic wdt_rst;
    logic svm_rst;
    logic soft_clr;
    logic wake;
    logic [31:0] wdt_limit;

    assign wr_ctrl = WR && hit(ADDR, OFS_CTRL);
    assign wr_stat = WR && hit(ADDR, OFS_STATUS);
    assign wake = sleep_q && !SLEEP;
    assign soft_clr = RST || chip_rst_q;

    // software reset accepted in any state
    assign sw_rst = wr_ctrl && WDATA[CTRL_SW_RESET];

    // monitor checked only awake or in doze
    assign svm_rst = (state_q == SQ_RUN) && svm_rst_en_q && !SLEEP && !svm_above;

    // external pin qualified by minimum low width
    always_ff @(posedge CLK) begin
        if (RST) begin
            ext_cnt_q <= 16'h0000;
            ext_hold_q <= 1'b0;
        end else if (ext_n) begin
            ext_cnt_q <= 16'h0000;
            ext_hold_q <= 1'b0;
        end else if (ext_cnt_q >= EXT_C) begin
            ext_hold_q <= 1'b1;
        end else begin
            ext_cnt_q <= ext_cnt_q + 16'h0001;
        end
    end

    // chip reset request from internal sources
    always_ff @(posedge CLK) begin
        if (RST) begin
            chip_rst_q <= 1'b0;
        end else begin
            chip_rst_q <= sw_rst || wdt_rst || svm_rst;
        end
    end

    // start-up sequencer
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= SQ_HOLD;
            tmr_q <= 16'h0000;
        end else if (!por_ok || ext_hold_q || chip_rst_q) begin
            state_q <= SQ_HOLD;
            tmr_q <= 16'h0000;
        end else begin
            case (state_q)
                SQ_HOLD: begin
                    // pin released and supply up: start
                    if (ext_n) begin
                        state_q <= SQ_OSC;
                        tmr_q <= 16'h0000;
                    end
                end
                SQ_OSC: begin
                    if (tmr_q == OSC_C) begin
                        state_q <= SQ_SVM0;
                    end else begin
                        tmr_q <= tmr_q + 16'h0001;
                    end
                end
                SQ_SVM0: begin
                    // regulators only with supply above the current level, the default only after board, software, watchdog or monitor reset
                    if (svm_above) begin
                        state_q <= SQ_REG;
                        tmr_q <= 16'h0000;
                    end
                end
                SQ_REG: begin
                    if (tmr_q == REG_C) begin
                        state_q <= SQ_NVM;
                        tmr_q <= 16'h0000;
                    end else begin
                        tmr_q <= tmr_q + 16'h0001;
                    end
                end
                SQ_NVM: begin
                    if (tmr_q == NVM_C) begin
                        state_q <= SQ_LOAD;
                        tmr_q <= 16'h0000;
                    end else begin
                        tmr_q <= tmr_q + 16'h0001;
                    end
                end
                SQ_LOAD: begin
                    if (tmr_q == LOAD_C) begin
                        state_q <= SQ_SVM1;
                    end else begin
                        tmr_q <= tmr_q + 16'h0001;
                    end
                end
                SQ_SVM1: begin
                    // release only above the new level
                    if (svm_above) begin
                        state_q <= SQ_RUN;
                    end
                end
                SQ_RUN: begin
                    state_q <= SQ_RUN;
                end
                default: begin
                    state_q <= SQ_HOLD;
                    tmr_q <= 16'h0000;
                end
            endcase
        end
    end

    // last reset cause
    always_ff @(posedge CLK) begin
        if (RST) begin
            cause_q <= CAUSE_POR;
        end else if (!por_ok) begin
            cause_q <= CAUSE_POR;
        end else if (ext_hold_q) begin
            cause_q <= CAUSE_EXT;
        end else if (sw_rst) begin
            cause_q <= CAUSE_SW;
        end else if (wdt_rst) begin
            cause_q <= CAUSE_WDT;
        end else if (svm_rst) begin
            cause_q <= CAUSE_SVM;
        end
    end

    // control register, cleared by board reset and by software, watchdog or monitor reset
    always_ff @(posedge CLK) begin
        if (soft_clr) begin
            svm_rst_en_q <= RST_SVM_RST_EN;
            irq_fall_en_q <= 1'b0;
            irq_rise_en_q <= 1'b0;
            wdt_en_q <= RST_WDT_EN;
            wdt_exc_mode_q <= 1'b0;
            wdt_pre_q <= RST_WDT_PRE;
        end else if (wr_ctrl) begin
            svm_rst_en_q <= WDATA[CTRL_SVM_RST_EN];
            irq_fall_en_q <= WDATA[CTRL_SVM_IRQ_FALL];
            irq_rise_en_q <= WDATA[CTRL_SVM_IRQ_RISE];
            wdt_en_q <= WDATA[CTRL_WDT_EN];
            wdt_exc_mode_q <= WDATA[CTRL_WDT_EXC];
            wdt_pre_q <= WDATA[CTRL_WDT_PRE_HI:CTRL_WDT_PRE_LO];
        end else if (wake) begin
            wdt_en_q <= RST_WDT_EN;
            wdt_pre_q <= RST_WDT_PRE;
        end
    end

    // monitor level: stored value at load, then software
    always_ff @(posedge CLK) begin
        if (soft_clr) begin
            svm_level_q <= RST_SVM_LEVEL;
        end else if (state_q == SQ_LOAD && tmr_q == 16'h0000) begin
            svm_level_q <= NVM_SVM_LEVEL;
        end else if (WR && hit(ADDR, OFS_SVM_LEVEL)) begin
            svm_level_q <= WDATA[2:0];
        end
    end

    // clock source selection
    always_ff @(posedge CLK) begin
        if (soft_clr) begin
            hs_xtal_q <= 1'b0;
            slow_sel_q <= RST_SLOW_SEL;
            slow_lock_q <= 1'b0;
        end else begin
            if (state_q != SQ_RUN || SLEEP) begin
                hs_xtal_q <= 1'b0;
            end else if (WR && hit(ADDR, OFS_CLK_SEL)) begin
                hs_xtal_q <= WDATA[CLK_HS_XTAL];
            end
            if (WR && hit(ADDR, OFS_CLK_SEL) && !slow_lock_q
                && WDATA[CLK_SLOW_HI:CLK_SLOW_LO] != SLOW_RC) begin
                slow_sel_q <= WDATA[CLK_SLOW_HI:CLK_SLOW_LO];
                slow_lock_q <= 1'b1;
            end
        end
    end

    // watchdog
    assign wdt_limit = WDT_B << wdt_pre_q;
    assign wdt_expire = wdt_en_q && (wdt_cnt_q >= wdt_limit - 32'h0000_0001);
    assign wdt_rst = wdt_expire && !wdt_exc_mode_q;

    always_ff @(posedge CLK) begin
        if (soft_clr || wake) begin
            wdt_cnt_q <= 32'h0000_0000;
        end else if (WR && hit(ADDR, OFS_WDT_RESTART)) begin
            wdt_cnt_q <= 32'h0000_0000;
        end else if (state_q != SQ_RUN || !wdt_en_q) begin
            wdt_cnt_q <= 32'h0000_0000;
        end else if (SLEEP || DBG_HALT) begin
            wdt_cnt_q <= wdt_cnt_q;
        end else if (wdt_expire) begin
            wdt_cnt_q <= 32'h0000_0000;
        end else begin
            wdt_cnt_q <= wdt_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            WDT_EXC <= 1'b0;
        end else begin
            WDT_EXC <= wdt_expire && wdt_exc_mode_q && state_q == SQ_RUN
                && !SLEEP && !DBG_HALT;
        end
    end

    // sticky flags, cleared only by board reset or a status write of one, set wins
    always_ff @(posedge CLK) begin
        if (RST) begin
            wdt_fired_q <= 1'b0;
            ram_invalid_q <= 1'b0;
        end else begin
            if (wdt_rst && state_q == SQ_RUN && !SLEEP && !DBG_HALT) begin
                wdt_fired_q <= 1'b1;
            end else if (wr_stat && WDATA[STAT_WDT_FIRED]) begin
                wdt_fired_q <= 1'b0;
            end
            if (sw_rst) begin
                ram_invalid_q <= 1'b1;
            end else if (wr_stat && WDATA[STAT_RAM_INVALID]) begin
                ram_invalid_q <= 1'b0;
            end
        end
    end

    // monitor crossing interrupt
    always_ff @(posedge CLK) begin
        if (RST) begin
            svm_prev_q <= 1'b0;
            SVM_IRQ <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            svm_prev_q <= svm_above;
            sleep_q <= SLEEP;
            SVM_IRQ <= (state_q == SQ_RUN) && !SLEEP
                && ((irq_fall_en_q && svm_prev_q && !svm_above)
                || (irq_rise_en_q && !svm_prev_q && svm_above));
        end
    end

    // analog and reset outputs
    always_ff @(posedge CLK) begin
        if (RST) begin
            HS_RC_EN <= 1'b0;
            XTAL_EN <= 1'b0;
            REG_EN <= 1'b0;
            NVM_INIT_REQ <= 1'b0;
            SYS_RST_N <= 1'b0;
        end else begin
            HS_RC_EN <= state_q != SQ_HOLD;
            XTAL_EN <= state_q != SQ_HOLD;
            REG_EN <= state_q == SQ_REG || state_q == SQ_NVM || state_q == SQ_LOAD
                || state_q == SQ_SVM1 || state_q == SQ_RUN;
            NVM_INIT_REQ <= state_q == SQ_NVM;
            // merged reset, released a cycle after run
            SYS_RST_N <= state_q == SQ_RUN && !chip_rst_q && por_ok && !ext_hold_q;
        end
    end

    assign SVM_LEVEL_SEL = svm_level_q;
    assign HS_CLK_XTAL = hs_xtal_q && xtal_ready;
    assign SLOW_CLK_SEL = slow_sel_q;

    // read data one cycle after strobe
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 16'h0000;
        end else if (!RD) begin
            RDATA <= 16'h0000;
        end else if (hit(ADDR, OFS_CTRL)) begin
            RDATA <= {4'h0, wdt_pre_q, 2'b00, wdt_exc_mode_q, wdt_en_q,
                irq_rise_en_q, irq_fall_en_q, svm_rst_en_q, 1'b0};
        end else if (hit(ADDR, OFS_STATUS)) begin
            RDATA <= {state_q, 1'b0, xtal_ready, svm_above, cause_q,
                ram_invalid_q, wdt_fired_q};
        end else if (hit(ADDR, OFS_SVM_LEVEL)) begin
            RDATA <= {13'h0000, svm_level_q};
        end else if (hit(ADDR, OFS_CLK_SEL)) begin
            RDATA <= {12'h000, slow_lock_q, slow_sel_q, hs_xtal_q};
        end else begin
            RDATA <= 16'h0000;
        end
    end
endmodule : rsw_top

// File: sim/rsw_properties.sv
// port checks for the reset sequencer top
// assumes one clock and the synchronous high reset of the top module
module rsw_properties #(
    parameter int NVM_WAIT_CYC = rsw_pkg::NVM_CYC,
    parameter int WDT_BASE = rsw_pkg::WDT_BASE_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // supply and pin
    input wire logic POR_OK,
    input wire logic EXT_RESET_N,
    input wire logic SVM_ABOVE,
    // sequencer outputs
    input wire logic NVM_INIT_REQ,
    input wire logic HS_RC_EN,
    input wire logic REG_EN,
    input wire logic [2:0] SVM_LEVEL_SEL,
    input wire logic SYS_RST_N,
    input wire logic SVM_IRQ,
    input wire logic WDT_EXC
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsw_pkg::*;
    logic [31:0] osc_q;
    logic [31:0] reg_q;
    logic [31:0] ext_q;
    // cycles of oscillator run before regulators
    always_ff @(posedge CLK) begin
        if (RST || !HS_RC_EN) osc_q <= '0;
        else if (!REG_EN) osc_q <= osc_q + 32'h0000_0001;
    end
    // cycles of regulator settle before memory init
    always_ff @(posedge CLK) begin
        if (RST || !REG_EN) reg_q <= '0;
        else if (!NVM_INIT_REQ) reg_q <= reg_q + 32'h0000_0001;
    end
    // length of the current low on the pin
    always_ff @(posedge CLK) begin
        if (RST || EXT_RESET_N) ext_q <= '0;
        else ext_q <= ext_q + 32'h0000_0001;
    end
    rst_hold_a: assert property (@(posedge CLK) RST |=> !SYS_RST_N)
        else $error("chip reset released during reset");
    lvl_default_a: assert property (@(posedge CLK) RST |=> SVM_LEVEL_SEL == SVM_LEVEL_2V0)
        else $error("threshold not at default");
    por_drop_a: assert property (@(posedge CLK) disable iff (RST)
        $fell(POR_OK) |-> ##[1:6] !SYS_RST_N)
        else $error("supply drop gave no reset");
    ext_hold_a: assert property (@(posedge CLK) disable iff (RST)
        ext_q >= 260 |-> !SYS_RST_N)
        else $error("long pin low gave no reset");
    osc_wait_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(REG_EN) |-> HS_RC_EN && osc_q >= OSC_CYC - 1)
        else $error("regulators enabled too early");
    reg_wait_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(NVM_INIT_REQ) |-> REG_EN && reg_q >= REG_CYC - 1)
        else $error("memory init before regulators settled");
    rel_above_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(SYS_RST_N) |-> REG_EN && !NVM_INIT_REQ && $past(SVM_ABOVE, 3) && $past(SVM_ABOVE, 4))
        else $error("release without supply above threshold");
    exc_keep_a: assert property (@(posedge CLK) disable iff (RST)
        WDT_EXC |-> SYS_RST_N ##1 (SYS_RST_N && !WDT_EXC))
        else $error("exception expiry reset the chip");
    irq_pulse_a: assert property (@(posedge CLK) disable iff (RST)
        SVM_IRQ |=> !SVM_IRQ)
        else $error("monitor interrupt longer than one cycle");
endmodule : rsw_properties

bind rsw_top rsw_properties #(.NVM_WAIT_CYC(NVM_WAIT_CYC), .WDT_BASE(WDT_BASE)) u_rsw_properties (
    .CLK(CLK), .RST(RST), .POR_OK(POR_OK), .EXT_RESET_N(EXT_RESET_N), .SVM_ABOVE(SVM_ABOVE),
    .NVM_INIT_REQ(NVM_INIT_REQ), .HS_RC_EN(HS_RC_EN), .REG_EN(REG_EN),
    .SVM_LEVEL_SEL(SVM_LEVEL_SEL), .SYS_RST_N(SYS_RST_N), .SVM_IRQ(SVM_IRQ), .WDT_EXC(WDT_EXC)
);

// File: sim/rsw_supply_model.sv
// supply rails, reset pin, crystal and stored threshold around the block
// assumes the bench sets the levels it wants through the control inputs
module rsw_supply_model (
    // bench controls
    input wire logic clk,
    input wire logic por_on,
    input wire logic pin_low,
    input wire logic svm_ok,
    input wire logic [2:0] level,
    // from the block
    input wire logic xtal_en,
    input wire logic nvm_req,
    // to the block
    output logic por_ok,
    output logic ext_reset_n,
    output logic svm_above,
    output logic xtal_ready,
    output logic [2:0] nvm_level
);
    timeunit 1ns;
    timeprecision 1ps;
    int xtal_cnt = 0;
    int hold_cnt = 0;
    assign por_ok = por_on;
    // pin pulled up when not driven low
    assign ext_reset_n = !pin_low;
    assign svm_above = svm_ok;
    always @(posedge clk) begin
        xtal_cnt <= xtal_en ? xtal_cnt + 1 : 0;
        hold_cnt <= nvm_req ? 0 : hold_cnt + 1;
    end
    assign xtal_ready = xtal_cnt > 40;
    // stored threshold valid only around the init read
    assign nvm_level = (nvm_req || hold_cnt < 4) ? level : ~level;
    // no serial flash here, so the shared slow clock pin is free
endmodule : rsw_supply_model

// File: sim/tb_rsw_top.sv
// self-checking bench for the reset sequencer top
// assumes rsw_supply_model on the supply side, bench acts as firmware
module tb_rsw_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rsw_pkg::*;
    localparam int NVM_W = 50;
    typedef struct packed {logic [15:0] d; logic [15:0] m;} rsw_exp_type;
    logic clk = 1'b0, rst = 1'b1, por_on = 1'b1, pin_low = 1'b1, svm_ok = 1'b0;
    logic sleep = 1'b0, dbg = 1'b0, wr_s = 1'b0, rd_s = 1'b0, rd_seen = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [2:0] level = 3'h0;
    logic por_ok, ext_n, svm_above, xtal_rdy, nvm_req, xtal_en, reg_en, hs_xtal;
    logic sys_rst_n, svm_irq, wdt_exc;
    logic [2:0] nvm_lvl, lvl_sel;
    logic [1:0] slow_sel;
    logic [15:0] rdata;
    integer seed = 32'h1a78;
    int n_errors = 0, samples_checked = 0, exc_cnt = 0, irq_cnt = 0;
    rsw_exp_type exp_q[$];

    rsw_top #(.NVM_WAIT_CYC(NVM_W), .WDT_BASE(8)) u_rsw_top (
        .CLK(clk), .RST(rst), .POR_OK(por_ok), .EXT_RESET_N(ext_n), .SVM_ABOVE(svm_above),
        .XTAL_READY(xtal_rdy), .SLEEP(sleep), .DBG_HALT(dbg), .NVM_SVM_LEVEL(nvm_lvl),
        .NVM_INIT_REQ(nvm_req), .HS_RC_EN(), .XTAL_EN(xtal_en), .REG_EN(reg_en),
        .SVM_LEVEL_SEL(lvl_sel), .HS_CLK_XTAL(hs_xtal), .SLOW_CLK_SEL(slow_sel),
        .SYS_RST_N(sys_rst_n), .SVM_IRQ(svm_irq), .WDT_EXC(wdt_exc), .ADDR(addr),
        .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata));
    rsw_supply_model u_rsw_supply_model (
        .clk(clk), .por_on(por_on), .pin_low(pin_low), .svm_ok(svm_ok), .level(level),
        .xtal_en(xtal_en), .nvm_req(nvm_req), .por_ok(por_ok), .ext_reset_n(ext_n),
        .svm_above(svm_above), .xtal_ready(xtal_rdy), .nvm_level(nvm_lvl));

    always #2 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("checked %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : bus_write

    // expectation noted here, compared by the read monitor
    task automatic bus_read(input logic [7:0] a, input logic [15:0] d, input logic [15:0] m);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        exp_q.push_back('{d: d & m, m: m});
        @(posedge clk);
        rd_s <= 1'b0;
    endtask : bus_read

    task automatic wait_rst(input logic v, input int lim, output int n);
        n = 0;
        while (sys_rst_n !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        check(16'(sys_rst_n), 16'(v));
    endtask : wait_rst

    task automatic wait_cnt(ref int c, input int from);
        int n;
        n = 0;
        while (c == from && n < 30) begin
            @(posedge clk);
            n++;
        end
        check(16'(c > from), 16'h0001);
    endtask : wait_cnt

    // read data stand one cycle after the strobe; pulses counted
    always @(posedge clk) begin
        rsw_exp_type e;
        rd_seen <= rd_s;
        if (wdt_exc === 1'b1) exc_cnt++;
        if (svm_irq === 1'b1) irq_cnt++;
        if (rd_seen) begin
            e = exp_q.pop_front();
            check(rdata & e.m, e.d); // tag sits at each bus_read
        end
    end

    initial begin
        #400000;
        n_errors++;
        results;
    end

    initial begin
        int n;
        level = 3'($random(seed));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (400) @(posedge clk);
        check(16'(sys_rst_n), 16'h0000);
        pin_low <= 1'b0;
        repeat (9000) @(posedge clk);
        check(16'(sys_rst_n), 16'h0000);
        check(16'(reg_en), 16'h0000);
        svm_ok <= 1'b1;
        wait_rst(1'b1, 9000, n);
        check(16'(n >= REG_CYC + NVM_W + LOAD_CYC), 16'h0001);
        check(16'(lvl_sel), 16'(level));
        bus_read(OFS_CTRL, 16'h0b12, 16'hffff);
        bus_read(OFS_SVM_LEVEL, 16'(level), 16'h0007);
        bus_read(OFS_STATUS, 16'h8064, 16'hfffd);
        bus_read(OFS_CLK_SEL, 16'h0000, 16'h000f);
        bus_read(8'h14, 16'h0000, 16'hffff);
        $display("test power_up done");
        bus_write(OFS_CLK_SEL, 16'h0003);
        bus_write(OFS_CLK_SEL, 16'h0005);
        repeat (2) @(posedge clk);
        check(16'(hs_xtal), 16'h0001);
        check(16'(slow_sel), 16'(SLOW_EXT));
        level <= 3'($random(seed));
        bus_write(OFS_CTRL, 16'h0b13);
        wait_rst(1'b0, 10, n);
        wait_rst(1'b1, 9000, n);
        check(16'(slow_sel), 16'(SLOW_RC));
        check(16'(hs_xtal), 16'h0000);
        bus_read(OFS_STATUS, 16'h000a, 16'h001f);
        bus_read(OFS_SVM_LEVEL, 16'(level), 16'h0007);
        bus_write(OFS_STATUS, 16'h0003);
        $display("test sw_reset done");
        bus_write(OFS_WDT_RESTART, 16'h0000);
        bus_write(OFS_CTRL, 16'h0012);
        repeat (12) bus_write(OFS_WDT_RESTART, 16'h0000);
        check(16'(sys_rst_n), 16'h0001);
        wait_rst(1'b0, 20, n);
        wait_rst(1'b1, 9000, n);
        bus_read(OFS_STATUS, 16'h000d, 16'h001d);
        bus_read(OFS_CTRL, 16'h0b12, 16'hffff);
        bus_write(OFS_STATUS, 16'h0003);
        $display("test wdt_reset done");
        dbg <= 1'b1;
        bus_write(OFS_WDT_RESTART, 16'h0000);
        bus_write(OFS_CTRL, 16'h0032);
        n = exc_cnt;
        repeat (100) @(posedge clk);
        check(16'(exc_cnt - n), 16'h0000);
        dbg <= 1'b0;
        wait_cnt(exc_cnt, n);
        check(16'(sys_rst_n), 16'h0001);
        bus_write(OFS_CTRL, 16'h0022);
        repeat (2) @(posedge clk);
        n = exc_cnt;
        repeat (100) @(posedge clk);
        check(16'(exc_cnt - n), 16'h0000);
        sleep <= 1'b1;
        repeat (20) @(posedge clk);
        sleep <= 1'b0;
        repeat (4) @(posedge clk);
        bus_read(OFS_CTRL, 16'h0b10, 16'h0f10);
        $display("test wdt_exception done");
        bus_write(OFS_WDT_RESTART, 16'h0000);
        bus_write(OFS_CTRL, 16'h0b1c);
        n = irq_cnt;
        svm_ok <= 1'b0;
        wait_cnt(irq_cnt, n);
        n = irq_cnt;
        svm_ok <= 1'b1;
        wait_cnt(irq_cnt, n);
        check(16'(sys_rst_n), 16'h0001);
        bus_write(OFS_CTRL, 16'h0b12);
        svm_ok <= 1'b0;
        wait_rst(1'b0, 20, n);
        svm_ok <= 1'b1;
        wait_rst(1'b1, 9000, n);
        bus_read(OFS_STATUS, 16'h0010, 16'h001c);
        $display("test svm done");
        por_on <= 1'b0;
        wait_rst(1'b0, 10, n);
        repeat (10) @(posedge clk);
        por_on <= 1'b1;
        wait_rst(1'b1, 9000, n);
        bus_read(OFS_STATUS, 16'h0000, 16'h001c);
        pin_low <= 1'b1;
        repeat (100) @(posedge clk);
        pin_low <= 1'b0;
        repeat (20) @(posedge clk);
        check(16'(sys_rst_n), 16'h0001);
        pin_low <= 1'b1;
        repeat (300) @(posedge clk);
        check(16'(sys_rst_n), 16'h0000);
        pin_low <= 1'b0;
        wait_rst(1'b1, 9000, n);
        bus_read(OFS_STATUS, 16'h0004, 16'h001c);
        repeat (3) @(posedge clk);
        $display("test por_ext done");
        results;
    end
endmodule : tb_rsw_top
